// ===== include/odl_pkg.sv
// constants, codes and helpers shared by the output delay tap control
package odl_pkg;

  // tap counter geometry: positions 0 .. 512 inclusive
  localparam int          TAP_W        = 9;
  localparam int          CNT_W        = 10;
  localparam logic [9:0]  TAP_FIRST    = 10'h000;
  localparam logic [9:0]  TAP_LAST     = 10'h200;
  localparam logic [10:0] TAP_POSITIONS = 11'h201;
  localparam logic [9:0]  TAP_ONE      = 10'h001;
  localparam logic [9:0]  TAP_GROUP    = 10'h008;
  localparam logic [9:0]  TAP_RESET    = 10'h000;

  // delay control styles
  localparam logic [1:0]  STYLE_STATIC    = 2'h0;
  localparam logic [1:0]  STYLE_STEPPING  = 2'h1;
  localparam logic [1:0]  STYLE_STEP_LOAD = 2'h2;

  // initial setting format and device generation
  localparam logic        FORMAT_TIME  = 1'b0;
  localparam logic        FORMAT_COUNT = 1'b1;
  localparam logic        GEN_FIRST    = 1'b0;
  localparam logic        GEN_LATER    = 1'b1;

  // chain roles
  localparam logic [1:0]  CHAIN_NONE   = 2'h0;
  localparam logic [1:0]  CHAIN_MASTER = 2'h1;
  localparam logic [1:0]  CHAIN_MIDDLE = 2'h2;
  localparam logic [1:0]  CHAIN_END    = 2'h3;

  // time limits in picoseconds
  localparam logic [10:0] MAX_PS_FIRST    = 11'h4E2;
  localparam logic [10:0] MAX_PS_LATER    = 11'h44C;
  localparam logic [10:0] CASCADE_MIN_PS  = 11'h4E2;
  localparam logic [10:0] INIT_DEFAULT    = 11'h000;
  // nominal tap delay used to turn picoseconds into taps; plain default
  localparam logic [10:0] TAP_PS          = 11'h005;

  // control sequencer states
  typedef enum logic [1:0] {
    ODL_ST_INIT = 2'b01,
    ODL_ST_RUN  = 2'b10
  } odl_state_t;

  // true for the styles that accept stepping and loading
  function automatic logic odl_style_dynamic(input logic [1:0] style);
    odl_style_dynamic = (style == STYLE_STEPPING) || (style == STYLE_STEP_LOAD);
  endfunction

endpackage

// ===== tb/odl_fabric_model.sv
// fabric-side control model driving tap steps and loads into the tap control block
`timescale 1ns/1ps
module odl_fabric_model (
  // clock
  input  wire logic       clock,
  // control towards the tap block
  output logic            step_en,
  output logic            step_dir,
  output logic            group_step,
  output logic            load,
  output logic [8:0]      tap_value_in,
  output logic            vt_compensation_enable
);
  // idle at time zero; compensation starts off because updates come first
  initial begin
    step_en = 1'b0;
    step_dir = 1'b0;
    group_step = 1'b0;
    load = 1'b0;
    tap_value_in = 9'h000;
    vt_compensation_enable = 1'b0;
  end

  // hold step enable for n sampling edges, all changes just after an edge
  // load stays low for the whole burst
  task automatic step(input int n, input logic dir, input logic grp);
    @(posedge clock);
    #1;
    step_en = 1'b1;
    step_dir = dir;
    group_step = grp;
    repeat (n) @(posedge clock);
    #1;
    step_en = 1'b0;
    step_dir = ~dir; // direction keeps moving while idle, so it must be ignored
  endtask

  // bus value stands one full cycle before load rises, step enable low
  task automatic load_tap(input logic [8:0] v);
    @(posedge clock);
    #1;
    tap_value_in = v;
    @(posedge clock);
    #1;
    load = 1'b1;
    @(posedge clock);
    #1;
    load = 1'b0;
    tap_value_in = ~v; // stale bus is not held, a late re-read would show
  endtask

  // compensation is switched only between updates
  task automatic set_vtc(input logic on);
    @(posedge clock);
    #1;
    vt_compensation_enable = on;
  endtask
endmodule

// ===== tb/output_delay_tap_control_bench.sv
// self-checking bench for the output delay tap control
`timescale 1ns/1ps
module output_delay_tap_control_bench;
  logic       clock;
  logic       rst_b;
  logic [1:0] delay_style;
  logic       sync_reset;
  logic       calib_ready;
  wire logic  step_en;
  wire logic  step_dir;
  wire logic  group_step;
  wire logic  load;
  wire logic  [8:0] tap_value_in;
  wire logic  vt_compensation_enable;
  logic [8:0] tap_value_out;
  logic       tap_at_last;
  logic       vtc_active;
  logic       init_format;
  logic       device_gen;
  logic [10:0] init_value;
  logic [1:0] chain_role;
  logic       delay_input;
  logic       init_clamped;
  logic       chain_misuse;
  logic       delay_output;
  int         n_errors;
  int         total_checks;
  int         cycles;

  odl_fabric_model partner_u (
    .clock(clock), .step_en(step_en), .step_dir(step_dir), .group_step(group_step),
    .load(load), .tap_value_in(tap_value_in), .vt_compensation_enable(vt_compensation_enable)
  );

  // configuration driven by the bench so every conversion path except unclamped time format gets reached
  odl_tap_ctrl dut_u (
    .clock(clock), .rst_b(rst_b), .delay_style(delay_style), .init_format(init_format),
    .device_gen(device_gen), .init_value(init_value), .chain_role(chain_role),
    .step_en(step_en), .step_dir(step_dir), .group_step(group_step), .load(load),
    .tap_value_in(tap_value_in), .sync_reset(sync_reset),
    .vt_compensation_enable(vt_compensation_enable), .calib_ready(calib_ready),
    .delay_input(delay_input), .tap_value_out(tap_value_out), .tap_at_last(tap_at_last),
    .vtc_active(vtc_active), .init_clamped(init_clamped), .chain_misuse(chain_misuse),
    .delay_output(delay_output)
  );

  // 40 MHz clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // tap position seen as 10 bits: the last-tap flag above the 9-bit bus
  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] seen);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic chk_tap(input string what, input logic [9:0] exp);
    chk(what, exp, {tap_at_last, tap_value_out});
  endtask

  // new initial setting, one edge for the conversion, then a synchronous reset
  task automatic reinit(input logic fmt, input logic gen, input logic [10:0] val,
                        input logic [1:0] role);
    init_format = fmt;
    device_gen = gen;
    init_value = val;
    chain_role = role;
    @(posedge clock);
    #1;
    sync_reset = 1'b1;
    @(posedge clock);
    #1;
    sync_reset = 1'b0;
  endtask

  // tap and the two configuration flags after a reinit
  task automatic chk_cfg(input logic [9:0] tap, input logic clamped, input logic misuse);
    chk_tap("reinit tap", tap);
    chk("init clamped", {9'h000, clamped}, {9'h000, init_clamped});
    chk("chain misuse", {9'h000, misuse}, {9'h000, chain_misuse});
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // hang guard, well above the roughly 63 cycles the sequence needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      $display("CHECK FAILED timeout expected done seen running");
      wrap_up();
    end
  end

  initial begin
    rst_b = 1'b0;
    delay_style = odl_pkg::STYLE_STEP_LOAD;
    sync_reset = 1'b0;
    calib_ready = 1'b0;
    init_format = 1'b1;
    device_gen = 1'b0;
    init_value = 11'h005;
    chain_role = 2'h0;
    delay_input = 1'b0;
    n_errors = 0;
    total_checks = 0;
    cycles = 0;
    repeat (4) @(posedge clock);
    #1;
    rst_b = 1'b1;
    // two edges for the initial setting to reach the tap
    repeat (2) @(posedge clock);
    #1;
    chk_tap("reset tap", 10'h005);
    partner_u.step(2, 1'b1, 1'b0);
    chk_tap("step up two", 10'h007);
    repeat (3) @(posedge clock);
    #1;
    chk_tap("idle hold", 10'h007);
    partner_u.step(1, 1'b0, 1'b0);
    chk_tap("step down", 10'h006);
    partner_u.load_tap(9'h1FE);
    chk_tap("bus load", 10'h1FE);
    partner_u.step(2, 1'b1, 1'b0);
    chk_tap("last tap", odl_pkg::TAP_LAST);
    partner_u.step(1, 1'b1, 1'b0);
    chk_tap("wrap up", 10'h000);
    partner_u.step(1, 1'b0, 1'b0);
    chk_tap("wrap down", 10'h200);
    partner_u.load_tap(9'h1FE);
    partner_u.step(1, 1'b1, 1'b1);
    chk_tap("group up wrap", 10'h005);
    partner_u.load_tap(9'h003);
    partner_u.step(1, 1'b0, 1'b1);
    chk_tap("group down wrap", 10'h1FC);
    delay_style = odl_pkg::STYLE_STEPPING;
    partner_u.load_tap(9'h0AA);
    chk_tap("stepping load", 10'h005);
    partner_u.step(2, 1'b1, 1'b0);
    chk_tap("stepping style", 10'h007);
    partner_u.step(1, 1'b1, 1'b1);
    chk_tap("group up", 10'h00F);
    delay_style = odl_pkg::STYLE_STATIC;
    partner_u.step(3, 1'b1, 1'b0);
    partner_u.load_tap(9'h010);
    chk_tap("static ignores", 10'h00F);
    // reset is only used once calibration reports ready
    calib_ready = 1'b1;
    delay_input = 1'b1;
    reinit(1'b1, 1'b0, 11'h005, 2'h0);
    chk_cfg(10'h005, 1'b0, 1'b0);
    chk("delay out high", 10'h001, {9'h000, delay_output}); // registered data path
    delay_input = 1'b0;
    reinit(1'b0, 1'b0, 11'h514, 2'h1);
    chk_cfg(10'h0FA, 1'b1, 1'b0);
    chk("delay out low", 10'h000, {9'h000, delay_output}); // registered data path
    reinit(1'b0, 1'b1, 11'h4B0, 2'h1);
    chk_cfg(10'h0DC, 1'b1, 1'b1);
    reinit(1'b1, 1'b0, 11'h300, 2'h3);
    chk_cfg(10'h200, 1'b1, 1'b0);
    partner_u.set_vtc(1'b1);
    @(posedge clock);
    #1;
    chk("vtc on", 10'h001, {9'h000, vtc_active});
    partner_u.set_vtc(1'b0);
    @(posedge clock);
    #1;
    chk("vtc off", 10'h000, {9'h000, vtc_active});
    // enable alone must not report compensation without calibration ready
    calib_ready = 1'b0;
    partner_u.set_vtc(1'b1);
    @(posedge clock);
    #1;
    chk("vtc not ready", 10'h000, {9'h000, vtc_active});
    wrap_up();
  end
endmodule

// ===== verilog/odl_init_conv.sv
// turns the initial delay setting into a registered tap count
`timescale 1ns/1ps
module odl_init_conv (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // initial setting
  input  wire logic        init_format,
  input  wire logic        device_gen,
  input  wire logic [10:0] init_value,
  // result
  output logic [9:0]       init_taps_ff,
  output logic             init_valid_ff,
  output logic             init_clamped_ff
);

  wire logic [10:0] max_ps;
  wire logic        ps_over;
  wire logic [10:0] ps_used;
  wire logic [10:0] ps_taps;
  wire logic        cnt_over;
  wire logic [9:0]  nxt_init_taps;
  wire logic        nxt_init_clamped;

  // time format is limited per generation, count format by the last tap
  assign max_ps   = (device_gen == odl_pkg::GEN_LATER) ? odl_pkg::MAX_PS_LATER
                                                       : odl_pkg::MAX_PS_FIRST;
  assign ps_over  = init_value > max_ps;
  assign ps_used  = ps_over ? max_ps : init_value;
  assign ps_taps  = ps_used / odl_pkg::TAP_PS;
  assign cnt_over = init_value > {1'b0, odl_pkg::TAP_LAST};
  assign nxt_init_taps = (init_format == odl_pkg::FORMAT_TIME) ? ps_taps[9:0] :
                         (cnt_over ? odl_pkg::TAP_LAST : init_value[9:0]);
  assign nxt_init_clamped = (init_format == odl_pkg::FORMAT_TIME) ? ps_over : cnt_over;

  // registered so the divider never sits in the tap update path
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      init_taps_ff    <= odl_pkg::TAP_RESET;
      init_valid_ff   <= 1'b0;
      init_clamped_ff <= 1'b0;
    end else begin
      init_taps_ff    <= nxt_init_taps;
      init_valid_ff   <= 1'b1;
      init_clamped_ff <= nxt_init_clamped;
    end
  end

endmodule

// ===== verilog/odl_tap_ctrl.sv
// tap selection control for a programmable output delay line
`timescale 1ns/1ps
//
// Functional notes
// - step enable and direction act only in stepping or step-and-load style
// - with step enable held high the tap moves one step per clock, of one tap or a group of eight
// - direction 1 increments, direction 0 decrements, sampled on the clock
// - step enable low keeps the tap unchanged whatever the direction
// - stepping starts on the first rising edge after step enable rises
// - stepping stops on the first rising edge after step enable falls
// - incrementing from tap 512 wraps to tap 0
// - decrementing from tap 0 wraps to tap 512
// - load takes the initial setting or the tap input bus, by style
// - in step-and-load style load copies the 9-bit tap input bus
// - load is active high and sampled on the control clock
// - the delay changes one tap at a time or in groups of eight
// - the current tap count is reported on a 9-bit output bus, with bit 9 on tap_at_last
// - synchronous reset sets the tap to the initial delay setting
// - compensation enable high, with calibration ready, holds delay over voltage and temperature
// - style is static, stepping or step-and-load, static by default
// - initial setting in ps per generation limit, or in taps; default 0
// - load, step enable and direction are all synchronous to the clock
// - chain role is none unless a delay beyond 1.25 ns needs cascading
module odl_tap_ctrl (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // configuration
  input  wire logic [1:0]  delay_style,
  input  wire logic        init_format,
  input  wire logic        device_gen,
  input  wire logic [10:0] init_value,
  input  wire logic [1:0]  chain_role,
  // fabric control
  input  wire logic        step_en,
  input  wire logic        step_dir,
  input  wire logic        group_step,
  input  wire logic        load,
  input  wire logic [8:0]  tap_value_in,
  input  wire logic        sync_reset,
  input  wire logic        vt_compensation_enable,
  // calibration controller
  input  wire logic        calib_ready,
  // data path
  input  wire logic        delay_input,
  // status
  output logic [8:0]       tap_value_out,
  output logic             tap_at_last,
  output logic             vtc_active,
  output logic             init_clamped,
  output logic             chain_misuse,
  output logic             delay_output
);

  odl_pkg::odl_state_t state_ff;
  odl_pkg::odl_state_t nxt_state;
  logic [9:0]          tap_ff;
  logic [9:0]          nxt_tap;
  logic                vtc_active_ff;
  logic                chain_misuse_ff;
  logic                delay_output_ff;
  wire logic [9:0]     init_taps;
  wire logic           init_valid;
  wire logic           init_clamped_w;
  wire logic [9:0]     step_tap;

  // decoded control
  wire logic           style_dyn;
  wire logic           style_bus;
  wire logic           running;
  wire logic           load_take;
  wire logic           step_take;
  wire logic [9:0]     load_src;
  wire logic           nxt_chain_misuse;

  // initial setting conversion, registered
  odl_init_conv u_init_conv (
    .clock           (clock),
    .rst_b           (rst_b),
    .init_format     (init_format),
    .device_gen      (device_gen),
    .init_value      (init_value),
    .init_taps_ff    (init_taps),
    .init_valid_ff   (init_valid),
    .init_clamped_ff (init_clamped_w)
  );

  // next position for a step from the current tap
  odl_tap_step u_tap_step (
    .tap        (tap_ff),
    .step_dir   (step_dir),
    .group_step (group_step),
    .tap_next   (step_tap)
  );

  // style decode; the static code is the power-on default of the style port
  assign style_dyn = odl_pkg::odl_style_dynamic(delay_style);
  assign style_bus = delay_style == odl_pkg::STYLE_STEP_LOAD;
  assign running   = state_ff == odl_pkg::ODL_ST_RUN;

  // load wins over a step; fabric should never overlap them anyway
  assign load_take = running && style_dyn && load;
  assign step_take = running && style_dyn && step_en && !load;
  assign load_src  = style_bus ? {1'b0, tap_value_in} : init_taps;

  // tap update priority: start-up, reset, load, step, hold
  assign nxt_tap = !running   ? (init_valid ? init_taps : tap_ff) :
                   sync_reset ? init_taps :
                   load_take  ? load_src :
                   step_take  ? step_tap :
                                tap_ff;

  // leave start-up once the converted initial setting is available
  assign nxt_state = (!running && init_valid) ? odl_pkg::ODL_ST_RUN : state_ff;

  // a cascade role is only sensible for a delay beyond one element
  assign nxt_chain_misuse = (chain_role != odl_pkg::CHAIN_NONE) &&
                            (init_format == odl_pkg::FORMAT_TIME) &&
                            (init_value <= odl_pkg::CASCADE_MIN_PS);

  // sequencer and tap register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= odl_pkg::ODL_ST_INIT;
      tap_ff   <= odl_pkg::TAP_RESET;
    end else begin
      state_ff <= nxt_state;
      tap_ff   <= nxt_tap;
    end
  end

  // compensation status and data path register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      vtc_active_ff   <= 1'b0;
      chain_misuse_ff <= 1'b0;
      delay_output_ff <= 1'b0;
    end else begin
      vtc_active_ff   <= vt_compensation_enable && calib_ready;
      chain_misuse_ff <= nxt_chain_misuse;
      delay_output_ff <= delay_input;
    end
  end

  // outputs straight from flops; tap 512 is the only code with bit 9 set
  assign tap_value_out = tap_ff[8:0];
  assign tap_at_last   = tap_ff[9];
  assign vtc_active    = vtc_active_ff;
  assign init_clamped  = init_clamped_w;
  assign chain_misuse  = chain_misuse_ff;
  assign delay_output  = delay_output_ff;

  // static style never moves once running, except by reset
  a_static_holds: assert property (@(posedge clock) disable iff (!rst_b)
    running && (delay_style == odl_pkg::STYLE_STATIC) && !sync_reset |=> $stable(tap_ff))
    else $error("static style tap moved");

  // a held step enable keeps moving the tap for consecutive cycles
  a_step_moves: assert property (@(posedge clock) disable iff (!rst_b)
    (running && style_dyn && step_en && !load && !sync_reset) [*2]
      |-> ##1 (tap_ff != $past(tap_ff)))
    else $error("tap did not move while stepping");

  // single increment below the last tap adds exactly one
  a_step_up: assert property (@(posedge clock) disable iff (!rst_b)
    step_take && !sync_reset && step_dir && !group_step && (tap_ff != odl_pkg::TAP_LAST)
      |=> tap_ff == $past(tap_ff) + odl_pkg::TAP_ONE)
    else $error("increment wrong");

  // single decrement above zero removes exactly one
  a_step_down: assert property (@(posedge clock) disable iff (!rst_b)
    step_take && !sync_reset && !step_dir && !group_step && (tap_ff != odl_pkg::TAP_FIRST)
      |=> tap_ff == $past(tap_ff) - odl_pkg::TAP_ONE)
    else $error("decrement wrong");

  // wrap from the last tap to zero
  a_wrap_up: assert property (@(posedge clock) disable iff (!rst_b)
    step_take && !sync_reset && step_dir && !group_step && (tap_ff == odl_pkg::TAP_LAST)
      |=> tap_ff == odl_pkg::TAP_FIRST)
    else $error("no wrap to tap 0");

  // wrap from zero to the last tap
  a_wrap_down: assert property (@(posedge clock) disable iff (!rst_b)
    step_take && !sync_reset && !step_dir && !group_step && (tap_ff == odl_pkg::TAP_FIRST)
      |=> tap_ff == odl_pkg::TAP_LAST)
    else $error("no wrap to last tap");

  // with step enable and load low the tap holds, direction is ignored
  a_idle_hold: assert property (@(posedge clock) disable iff (!rst_b)
    running && !step_en && !load && !sync_reset |=> tap_ff == $past(tap_ff))
    else $error("tap changed while idle");

  // bus load copies the sampled tap input
  a_load_bus: assert property (@(posedge clock) disable iff (!rst_b)
    running && load && style_bus && !sync_reset
      |=> tap_ff == {1'b0, $past(tap_value_in)})
    else $error("bus load wrong");

  // load in stepping style returns to the initial setting
  a_load_init: assert property (@(posedge clock) disable iff (!rst_b)
    running && load && (delay_style == odl_pkg::STYLE_STEPPING) && !sync_reset
      |=> tap_ff == $past(init_taps))
    else $error("initial load wrong");

  // group step up adds eight when there is room
  a_group_up: assert property (@(posedge clock) disable iff (!rst_b)
    step_take && !sync_reset && step_dir && group_step &&
      (tap_ff <= odl_pkg::TAP_LAST - odl_pkg::TAP_GROUP)
      |=> tap_ff == $past(tap_ff) + odl_pkg::TAP_GROUP)
    else $error("group step wrong");

  // synchronous reset restores the initial setting
  a_reset_init: assert property (@(posedge clock) disable iff (!rst_b)
    running && sync_reset |=> tap_ff == $past(init_taps))
    else $error("reset did not restore initial tap");

  // compensation status follows enable and ready one cycle later
  a_vtc_follow: assert property (@(posedge clock) disable iff (!rst_b)
    ##1 vtc_active == $past(vt_compensation_enable && calib_ready))
    else $error("compensation status wrong");

  // tap never exceeds the last position
  a_tap_range: assert property (@(posedge clock) disable iff (!rst_b)
    tap_ff <= odl_pkg::TAP_LAST)
    else $error("tap out of range");

  // start-up reaches running within two edges of reset release
  a_start_bound: assert property (@(posedge clock) disable iff (!rst_b)
    !running |-> ##[1:2] running)
    else $error("start-up stuck");

endmodule

// ===== verilog/odl_tap_step.sv
// modular tap stepper: next position one tap or one group up or down
`timescale 1ns/1ps
module odl_tap_step (
  // current position and request
  input  wire logic [9:0] tap,
  input  wire logic       step_dir,
  input  wire logic       group_step,
  // result
  output logic [9:0]      tap_next
);

  // widen by one bit so the wrap test sees the carry
  wire logic [10:0] step_amt;
  wire logic [10:0] up_sum;
  wire logic [10:0] up_wrap;
  wire logic [10:0] dn_wrap;
  wire logic [10:0] dn_diff;
  wire logic        up_over;
  wire logic        dn_under;

  assign step_amt = group_step ? {1'b0, odl_pkg::TAP_GROUP} : {1'b0, odl_pkg::TAP_ONE};
  assign up_sum   = {1'b0, tap} + step_amt;
  assign up_over  = up_sum >= odl_pkg::TAP_POSITIONS;
  assign up_wrap  = up_sum - odl_pkg::TAP_POSITIONS;
  assign dn_under = {1'b0, tap} < step_amt;
  assign dn_diff  = {1'b0, tap} - step_amt;
  assign dn_wrap  = {1'b0, tap} + odl_pkg::TAP_POSITIONS - step_amt;

  // past the last tap comes tap 0, below tap 0 comes the last tap
  assign tap_next = step_dir ? (up_over ? up_wrap[9:0] : up_sum[9:0])
                             : (dn_under ? dn_wrap[9:0] : dn_diff[9:0]);

endmodule
